// ### shared/zpath_pkg.sv
// Constants, register map and carrier types for the Z path and length normaliser.
// Assumes one 50 MHz clock, synchronous active-high reset, same-clock stage strobes.
package zpath_pkg;

	localparam int Z_W = 8;
	localparam int MAG_W = 12;
	localparam int NORM_W = 8;
	localparam int EXP_W = 10;
	localparam int SHIFT_MAX = 9;
	localparam int MOVE_SHIFT = 2;
	localparam int CNT_W = 3;
	localparam logic [3:0] SHIFT_SUM = 4'h8;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_ZIN = 4'h8;
	localparam logic [ADDR_W-1:0] ADDR_ZOUT = 4'hC;

	localparam int CTRL_REL_BIT = 0;
	localparam int CTRL_MOVE_BIT = 1;
	localparam int STAT_ODD_BIT = 0;
	localparam int STAT_YGX_BIT = 1;
	localparam int STAT_SERIAL_BIT = 2;

	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [Z_W-1:0] Z_RESET = 8'h00;

	// Result of the magnitude compare and normalise network
	typedef struct packed {
		logic y_exceeds_x;
		logic [NORM_W-1:0] bigger_norm;
		logic [NORM_W-1:0] lesser_norm;
		logic [EXP_W-1:0] exponent;
		logic exponent_six_plus;
		logic [CNT_W-1:0] shift_count_a;
		logic [CNT_W-1:0] shift_count_b;
	} norm_result_t;

	// Register port request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

endpackage : zpath_pkg

// ### hdl/magnitude_normalizer.sv
// Compare, normalise and exchange of the X and Y delta magnitudes.
// Purely combinational; the parent captures the result on its stage 3 strobe, except the compare flag, which it registers every cycle.
`timescale 1ns/1ps

module magnitude_normalizer
	import zpath_pkg::*;
(
	input wire logic [MAG_W-1:0] abs_delta_x_n,
	input wire logic [MAG_W-1:0] abs_delta_y_n,
	input wire logic move_cmd,
	output norm_result_t result
);

	// Leading common zero count, capped at nine
	function automatic logic [3:0] common_zeros(input logic [MAG_W-1:0] both);
		logic [3:0] n;
		logic run;
		n = 4'h0;
		run = 1'b1;
		for (int i = MAG_W - 1; i >= 0; i--)
		begin
			run = run & ~both[i];
			if (run && n < 4'(SHIFT_MAX))
			begin
				n = n + 4'h1;
			end
		end
		return n;
	endfunction : common_zeros

	logic [MAG_W-1:0] mag_x;
	logic [MAG_W-1:0] mag_y;
	logic [MAG_W-1:0] both_nz;
	logic [3:0] shift;
	logic [3:0] move_shift;
	logic shift_four_plus_n;
	logic shift_eight_plus_n;
	logic shift_nine_plus_n;
	logic [NORM_W-1:0] norm_x;
	logic [NORM_W-1:0] norm_y;
	logic [CNT_W-1:0] cnt_a;

	// Inputs arrive active low
	assign mag_x = ~abs_delta_x_n;
	assign mag_y = ~abs_delta_y_n;
	assign both_nz = mag_x | mag_y;

	// Terms look only at the preceding positions, never at a one
	assign shift_four_plus_n = |both_nz[11:8];
	assign shift_eight_plus_n = |both_nz[11:4];
	assign shift_nine_plus_n = |both_nz[11:3];
	assign shift = common_zeros(both_nz);

	// Upper and lower shifter halves ORed like the open-collector bus
	function automatic logic [NORM_W-1:0] shifted(input logic [MAG_W-1:0] m, input logic [3:0] s);
		logic [NORM_W-1:0] hi;
		logic [NORM_W-1:0] lo;
		hi = NORM_W'({4'h0, m[11:4]} << s);
		lo = NORM_W'((16'(m[3:0]) << s) >> 4);
		return hi | lo;
	endfunction : shifted

	assign norm_x = shifted(mag_x, shift);
	assign norm_y = shifted(mag_y, shift);

	// Counts stay in 1..7 so both fit three bits and sum to eight
	assign cnt_a = (shift == 4'h0) ? 3'h1 : (shift >= 4'h7) ? 3'h7 : shift[2:0];
	assign move_shift = move_cmd ? ((shift + 4'(MOVE_SHIFT) > 4'(SHIFT_MAX)) ? 4'(SHIFT_MAX)
		: shift + 4'(MOVE_SHIFT)) : shift;

	always_comb
	begin
		result.y_exceeds_x = mag_y > mag_x;
		result.bigger_norm = result.y_exceeds_x ? norm_y : norm_x;
		result.lesser_norm = result.y_exceeds_x ? norm_x : norm_y;
		for (int k = 0; k < EXP_W; k++)
		begin
			result.exponent[k] = (move_shift >= 4'(k));
		end
		result.exponent[4] = result.exponent[4] & ~(shift_four_plus_n & ~move_cmd);
		result.exponent[8] = result.exponent[8] & ~(shift_eight_plus_n & ~move_cmd);
		result.exponent[9] = result.exponent[9] & ~(shift_nine_plus_n & ~move_cmd);
		result.exponent_six_plus = result.exponent[6];
		result.shift_count_a = cnt_a;
		result.shift_count_b = CNT_W'(SHIFT_SUM - {1'b0, cnt_a});
	end

endmodule : magnitude_normalizer

// ### hdl/z_path_and_length_normalizer.sv
// Z coordinate datapath plus line length preprocessing, three register stages.
// Stage strobes come from a pipeline controller on the same clock; strap is a pin.
`timescale 1ns/1ps

module z_path_and_length_normalizer
	import zpath_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic serial_strap,
	input wire logic [Z_W-1:0] z_in,
	input wire logic stage1_strobe,
	input wire logic stage2_strobe,
	input wire logic stage3_strobe,
	input wire logic [MAG_W-1:0] abs_delta_x_n,
	input wire logic [MAG_W-1:0] abs_delta_y_n,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	output logic serial_out,
	output logic [Z_W-1:0] z_out,
	output logic y_exceeds_x,
	output logic [NORM_W-1:0] bigger_norm,
	output logic [NORM_W-1:0] lesser_norm,
	output logic [EXP_W-1:0] line_exponent,
	output logic exponent_six_plus,
	output logic [CNT_W-1:0] shift_count_a,
	output logic [CNT_W-1:0] shift_count_b
);

	// Whole module state in one record
	typedef struct packed {
		logic [2:0] strap_sync;
		logic serial_mode;
		logic [Z_W-1:0] input_reg;
		logic serial_out;
		logic [Z_W-1:0] true_even;
		logic [Z_W-1:0] true_odd;
		logic [Z_W-1:0] coded_even;
		logic [Z_W-1:0] coded_odd;
		logic load_odd;
		logic last_odd;
		logic stage3_odd;
		logic [Z_W-1:0] z_out;
		logic select_relative;
		logic move_cmd;
		logic y_exceeds_x;
		logic [NORM_W-1:0] bigger_norm;
		logic [NORM_W-1:0] lesser_norm;
		logic [EXP_W-1:0] line_exponent;
		logic exponent_six_plus;
		logic [CNT_W-1:0] shift_count_a;
		logic [CNT_W-1:0] shift_count_b;
		logic [DATA_W-1:0] rdata;
	} state_t;

	state_t state_q;
	state_t state_d;
	reg_req_t req;
	norm_result_t norm;
	logic [Z_W-1:0] prior_point_bus;
	logic [Z_W-1:0] absolute_input_bus;
	logic [Z_W-1:0] relative_sum;
	logic [Z_W-1:0] new_value;

	// Read mux shared by the register port
	function automatic logic [DATA_W-1:0] read_word(input state_t s, input logic [ADDR_W-1:0] a);
		logic [DATA_W-1:0] w;
		w = '0;
		unique case (a)
			ADDR_CTRL:
			begin
				w[CTRL_REL_BIT] = s.select_relative;
				w[CTRL_MOVE_BIT] = s.move_cmd;
			end
			ADDR_STATUS:
			begin
				w[STAT_ODD_BIT] = s.load_odd;
				w[STAT_YGX_BIT] = s.y_exceeds_x;
				w[STAT_SERIAL_BIT] = s.serial_mode;
			end
			ADDR_ZIN:
			begin
				w[Z_W-1:0] = s.input_reg;
			end
			ADDR_ZOUT:
			begin
				w[Z_W-1:0] = s.z_out;
			end
			default:
			begin
				w = '0; // Unmapped addresses read zero
			end
		endcase
		return w;
	endfunction : read_word

	// Bundle the register port
	assign req.addr = reg_addr;
	assign req.wdata = reg_wdata;
	assign req.wr = reg_wr;
	assign req.rd = reg_rd;

	// Compare, normalise and exchange settle ahead of the stage 3 strobe
	magnitude_normalizer u_norm (
		.abs_delta_x_n(abs_delta_x_n),
		.abs_delta_y_n(abs_delta_y_n),
		.move_cmd(state_q.move_cmd),
		.result(norm)
	);

	// The previous endpoint is the register loaded last
	assign prior_point_bus = state_q.last_odd ? state_q.true_odd : state_q.true_even;
	assign absolute_input_bus = state_q.input_reg;
	// Carry out is dropped; the upper extension is not part of this block
	assign relative_sum = Z_W'(prior_point_bus + absolute_input_bus);
	assign new_value = state_q.select_relative ? relative_sum : absolute_input_bus;

	// Next-state logic for every stage
	always_comb
	begin
		state_d = state_q;
		state_d.rdata = '0;

		// Strap passes three flops; a change counts once the last two agree
		state_d.strap_sync = {state_q.strap_sync[1:0], serial_strap};
		if (state_q.strap_sync[1] == state_q.strap_sync[2])
		begin
			state_d.serial_mode = state_q.strap_sync[2];
		end

		// Stage 1: parallel load or serial shift, lowest pin feeds in
		if (stage1_strobe)
		begin
			if (state_q.serial_mode)
			begin
				state_d.input_reg = {state_q.input_reg[Z_W-2:0], z_in[0]};
			end
			else
			begin
				state_d.input_reg = z_in;
			end
		end
		// MSB leaves on the serial output only in serial mode
		state_d.serial_out = state_d.serial_mode & state_d.input_reg[Z_W-1];

		// Stage 2: only the selected register of the pair loads
		if (stage2_strobe)
		begin
			if (state_q.load_odd)
			begin
				state_d.true_odd = new_value;
			end
			else
			begin
				state_d.true_even = new_value;
			end
			state_d.last_odd = state_q.load_odd;
			state_d.load_odd = ~state_q.load_odd;
		end

		// Stage 3: Z copied straight through, all bits on one strobe
		if (stage3_strobe)
		begin
			if (state_q.last_odd)
			begin
				state_d.coded_odd = state_q.true_odd;
				state_d.z_out = state_q.true_odd;
			end
			else
			begin
				state_d.coded_even = state_q.true_even;
				state_d.z_out = state_q.true_even;
			end
			state_d.stage3_odd = state_q.last_odd;
			state_d.bigger_norm = norm.bigger_norm;
			state_d.lesser_norm = norm.lesser_norm;
			state_d.line_exponent = norm.exponent;
			state_d.exponent_six_plus = norm.exponent_six_plus;
			state_d.shift_count_a = norm.shift_count_a;
			state_d.shift_count_b = norm.shift_count_b;
		end

		// Indicator follows the live compare, one cycle late
		state_d.y_exceeds_x = norm.y_exceeds_x;

		// Register port: write the control word, read one cycle later
		if (req.wr && req.addr == ADDR_CTRL)
		begin
			state_d.select_relative = req.wdata[CTRL_REL_BIT];
			state_d.move_cmd = req.wdata[CTRL_MOVE_BIT];
		end
		if (req.rd)
		begin
			state_d.rdata = read_word(state_q, req.addr);
		end
	end

	// State register; strap bits reset to parallel until sampled
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_q <= '0;
			state_q.input_reg <= Z_RESET;
			state_q.z_out <= Z_RESET;
			state_q.select_relative <= CTRL_RESET[CTRL_REL_BIT];
			state_q.move_cmd <= CTRL_RESET[CTRL_MOVE_BIT];
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// Outputs straight from the state record
	assign reg_rdata = state_q.rdata;
	assign serial_out = state_q.serial_out;
	assign z_out = state_q.z_out;
	assign y_exceeds_x = state_q.y_exceeds_x;
	assign bigger_norm = state_q.bigger_norm;
	assign lesser_norm = state_q.lesser_norm;
	assign line_exponent = state_q.line_exponent;
	assign exponent_six_plus = state_q.exponent_six_plus;
	assign shift_count_a = state_q.shift_count_a;
	assign shift_count_b = state_q.shift_count_b;

endmodule : z_path_and_length_normalizer

// ### tb/zpath_assertions.sv
// Port checker for the Z path and length normaliser.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps

module zpath_checker
	import zpath_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic serial_strap,
	input wire logic stage3_strobe,
	input wire logic [MAG_W-1:0] abs_delta_x_n,
	input wire logic [MAG_W-1:0] abs_delta_y_n,
	input wire logic reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic serial_out,
	input wire logic [Z_W-1:0] z_out,
	input wire logic y_exceeds_x,
	input wire logic [NORM_W-1:0] bigger_norm,
	input wire logic [NORM_W-1:0] lesser_norm,
	input wire logic [EXP_W-1:0] line_exponent,
	input wire logic exponent_six_plus,
	input wire logic [CNT_W-1:0] shift_count_a,
	input wire logic [CNT_W-1:0] shift_count_b
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	// Inputs arrive inverted, so compare their complements
	property p_ygx;
		!reset |=> y_exceeds_x == (~$past(abs_delta_y_n) > ~$past(abs_delta_x_n));
	endproperty
	a_ygx: assert property (p_ygx) else $error("compare flag wrong");
	property p_sum;
		stage3_strobe |=> ({1'b0, shift_count_a} + {1'b0, shift_count_b}) == SHIFT_SUM;
	endproperty
	a_sum: assert property (p_sum) else $error("shift counts do not add to eight");
	property p_six;
		exponent_six_plus == line_exponent[6];
	endproperty
	a_six: assert property (p_six) else $error("six plus flag off");
	property p_exp0;
		stage3_strobe |=> line_exponent[0];
	endproperty
	a_exp0: assert property (p_exp0) else $error("exponent bit zero clear");
	property p_order;
		stage3_strobe |=> bigger_norm >= lesser_norm;
	endproperty
	a_order: assert property (p_order) else $error("bigger below lesser");
	property p_rdata;
		!reg_rd |=> reg_rdata == '0;
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data outside read slot");
	// Strap goes through a synchroniser, so allow five low samples
	property p_serial_out;
		!serial_strap [*5] |=> !serial_out;
	endproperty
	a_serial_out: assert property (p_serial_out) else $error("serial out in parallel mode");
	property p_hold;
		!stage3_strobe |=> $stable({z_out, bigger_norm, lesser_norm});
	endproperty
	a_hold: assert property (p_hold) else $error("stage 3 moved without strobe");
endmodule : zpath_checker

bind z_path_and_length_normalizer zpath_checker chk_u (.clk, .reset, .serial_strap,
	.stage3_strobe, .abs_delta_x_n, .abs_delta_y_n, .reg_rd, .reg_rdata, .serial_out,
	.z_out, .y_exceeds_x, .bigger_norm, .lesser_norm, .line_exponent, .exponent_six_plus,
	.shift_count_a, .shift_count_b);

// ### tb/pipe_feeder.sv
// Model of the pipeline controller and XY cards driving stages 2 and 3.
// Assumes the bench has loaded the input register before raising go.
`timescale 1ns/1ps

module pipe_feeder
	import zpath_pkg::*;
(
	input wire logic clk,
	input wire logic go,
	input wire logic [1:0] gap,
	input wire logic [MAG_W-1:0] mag_x,
	input wire logic [MAG_W-1:0] mag_y,
	output logic stage2_strobe = 1'b0,
	output logic stage3_strobe = 1'b0,
	output logic done = 1'b0,
	output logic [MAG_W-1:0] abs_delta_x_n,
	output logic [MAG_W-1:0] abs_delta_y_n
);
	// Magnitudes travel inverted on the cable
	assign abs_delta_x_n = ~mag_x;
	assign abs_delta_y_n = ~mag_y;

	// One stage 2 then one stage 3 pulse; gap idles mimic a choked pipeline
	always
	begin
		@(posedge clk);
		if (go)
		begin
			repeat (gap) @(posedge clk);
			stage2_strobe <= 1'b1;
			@(posedge clk);
			stage2_strobe <= 1'b0;
			repeat (gap) @(posedge clk);
			stage3_strobe <= 1'b1;
			@(posedge clk);
			stage3_strobe <= 1'b0;
			done <= 1'b1;
			@(posedge clk);
			done <= 1'b0;
		end
	end
endmodule : pipe_feeder

// ### tb/z_path_and_length_normalizer_tb.sv
// Self-checking bench for the Z path and length normaliser.
// Assumes pipe_feeder for stages 2 and 3 and the bound port checker.
`timescale 1ns/1ps

module z_path_and_length_normalizer_tb
	import zpath_pkg::*;
;
	logic clk = 1'b0, reset = 1'b1, serial_strap = 1'b0, stage1_strobe = 1'b0;
	logic reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0, done, serial_out, y_exceeds_x;
	logic stage2_strobe, stage3_strobe, exponent_six_plus;
	logic [1:0] gap = 2'h0;
	logic [Z_W-1:0] z_in = 8'h00, z_out, prior, zv;
	logic [ADDR_W-1:0] reg_addr = 4'h0;
	logic [DATA_W-1:0] reg_wdata = 32'h0000_0000, reg_rdata, rv, r;
	logic [MAG_W-1:0] mx = 12'h000, my = 12'h000, abs_delta_x_n, abs_delta_y_n;
	logic [NORM_W-1:0] bigger_norm, lesser_norm;
	logic [EXP_W-1:0] line_exponent;
	logic [CNT_W-1:0] shift_count_a, shift_count_b;
	logic [31:0] seed = 32'h0000_0026;
	int bad_count = 0, checked = 0, np = 0, n;

	always #10 clk = ~clk;

	z_path_and_length_normalizer dut_u (.clk, .reset, .serial_strap, .z_in, .stage1_strobe,
		.stage2_strobe, .stage3_strobe, .abs_delta_x_n, .abs_delta_y_n, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .serial_out, .z_out, .y_exceeds_x,
		.bigger_norm, .lesser_norm, .line_exponent, .exponent_six_plus, .shift_count_a,
		.shift_count_b);
	pipe_feeder feed_u (.clk, .go, .gap, .mag_x(mx), .mag_y(my), .stage2_strobe,
		.stage3_strobe, .done, .abs_delta_x_n, .abs_delta_y_n);

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task complete_run();
		$display("mismatches %0d comparisons %0d", bad_count, checked);
		if (bad_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	task reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : reg_write

	// Read data stand only in the cycle after the strobe
	task reg_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : reg_read

	// One endpoint through all three stages, expectations worked out alongside
	task automatic point(input logic [7:0] z, input logic rel, input logic mv,
		input logic [11:0] x, input logic [11:0] y, input logic ser);
		int s, ee, c;
		logic [11:0] a, b;
		logic [9:0] e;
		s = 0;
		while (s < SHIFT_MAX && ((x | y) << s) < 12'h800) s++;
		a = x << s;
		b = y << s;
		if (y > x) {a, b} = {b, a};
		ee = mv ? ((s + MOVE_SHIFT > SHIFT_MAX) ? SHIFT_MAX : s + MOVE_SHIFT) : s;
		// Shift-term gating of bits 4, 8 and 9 is bypassed for moves
		for (int k = 0; k < EXP_W; k++) e[k] = (k <= ee) && !(!mv && (k == 4 || k >= 8) && s < k);
		c = (s < 1) ? 1 : ((s > 7) ? 7 : s);
		reg_write(ADDR_CTRL, {30'h0000_0000, mv, rel});
		for (int i = ser ? 7 : 0; i >= 0; i--)
		begin
			@(posedge clk);
			stage1_strobe <= 1'b1;
			z_in <= ser ? {7'h00, z[i]} : z;
		end
		@(posedge clk);
		stage1_strobe <= 1'b0;
		mx <= x;
		my <= y;
		gap <= 2'(rnd());
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		zv = rel ? z + prior : z;
		prior = zv;
		np++;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (done !== 1'b1 && n < 40);
		if (n >= 40)
		begin
			bad_count++;
			complete_run();
		end
		#1 chk(z_out, zv);
		chk(y_exceeds_x, y > x);
		chk({bigger_norm, lesser_norm}, {a[11:4], b[11:4]});
		chk(line_exponent, e);
		chk({shift_count_a, shift_count_b}, {3'(c), 3'(8 - c)});
		chk(serial_out, ser & z[7]);
		reg_read(ADDR_ZIN, rv);
		chk(rv, z);
		reg_read(ADDR_STATUS, rv);
		chk(rv, {ser, y > x, np[0]});
		reg_read(ADDR_CTRL, rv);
		chk(rv, {mv, rel});
	endtask : point

	// Corners first, then random traffic in both input modes
	initial
	begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		prior = 8'h00;
		reg_read(4'h2, rv);
		chk(rv, 32'h0000_0000);
		reg_write(ADDR_STATUS, 32'hFFFF_FFFF);
		reg_read(ADDR_STATUS, rv);
		chk(rv, 32'h0000_0000);
		point(8'hFF, 1'b0, 1'b0, 12'h000, 12'h000, 1'b0);
		point(8'h01, 1'b1, 1'b0, 12'hFFF, 12'h800, 1'b0);
		point(8'h80, 1'b1, 1'b1, 12'h001, 12'h002, 1'b0);
		point(8'h3C, 1'b1, 1'b1, 12'h0F0, 12'h0F0, 1'b0);
		for (int i = 0; i < 24; i++)
		begin
			r = rnd();
			point(r[7:0], r[8], r[9], r[21:10] >> r[27:24], 12'(rnd()) >> r[31:28], 1'b0);
		end
		serial_strap <= 1'b1;
		repeat (6) @(posedge clk);
		for (int i = 0; i < 4; i++)
		begin
			r = rnd();
			point(r[7:0], r[8], r[9], r[19:8], r[31:20], 1'b1);
		end
		serial_strap <= 1'b0;
		repeat (6) @(posedge clk);
		// Mid-run reset must clear stage 3 and restart on the even register
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		prior = 8'h00;
		np = 0;
		#1 chk(z_out, 32'h0000_0000);
		point(8'h5A, 1'b1, 1'b0, 12'h010, 12'h003, 1'b0);
		complete_run();
	end
endmodule : z_path_and_length_normalizer_tb
